// file: csp_clk_spi_top.sv
// csp_clk_spi_top: system clock source selection and serial slave byte framing
// assumes: SCLK is the master's shift clock, stopped outside frames;
// clock gate enables drive an external glitch-free gate cell
//
// Functional notes
// - after reset run from the rc clock until 65,536 hf edges counted.
// - leaving stop mode restarts the warmup count from zero.
// - external-clock bit disables the crystal; cleared only by writing 0 or by power-on reset.
// - low-power mode or warmup in progress selects the rc clock.
// - without hf edges warmup never completes; rc clock stays selected.
// - polarity bit picks idle level and active shift clock edge.
// - phase bit picks sampling on active or on inactive edge.
// - every character is eight bits, most significant bit first.
// - after reset the serial format is polarity 0, phase 0.
// - new format applies only when the mirror update is requested.
// - in phase 1 bytes follow back to back under one select.
// - slave only; each byte is exchanged in both directions at once.
// - a dedicated interrupt request output separate from the serial lines.
// - mirror update copies all mirrored configuration into hardware.
`timescale 1ns/1ps
module csp_clk_spi_top
    import csp_pkg::*;
#(
    parameter logic [CSP_WARMUP_W-1:0] WARMUP_CYCLES = CSP_WARMUP_CYCLES,
    parameter int FIFO_DEPTH = CSP_FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic POR_RST_N,
    input wire logic OSC_IN_PIN,
    input wire logic LOW_POWER_MODE,
    input wire logic STOP_MODE,
    input wire logic EXT_HF_CLOCK_SELECT_WR,
    input wire logic EXT_HF_CLOCK_SELECT_VAL,
    output logic EXT_HF_CLOCK_SELECT,
    output logic OSC_ENABLE,
    output csp_clk_stat_s CLK_STATUS,
    input wire csp_cfg_s SERIAL_PORT_CONFIG_MIRROR,
    input wire logic MIRROR_TO_HW_UPDATE,
    output csp_cfg_s SERIAL_PORT_CONFIG,
    input wire logic SCLK,
    input wire logic MOSI,
    input wire logic SSEL,
    output logic MISO_O,
    output logic MISO_OE,
    output logic [CSP_BYTE_W-1:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic RX_OVERRUN,
    input wire logic [CSP_BYTE_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic IRQ_REQ,
    output logic IRQ_N
);

    // ***************************************************
    // external clock bit, only a write of 0 or power-on reset clears it
    // ***************************************************
    logic ext_reg, ext_next;

    always_comb begin
        ext_next = ext_reg;
        if (EXT_HF_CLOCK_SELECT_WR) begin
            ext_next = EXT_HF_CLOCK_SELECT_VAL;
        end
    end

    always_ff @(posedge CLK or negedge POR_RST_N) begin
        if (!POR_RST_N) begin
            ext_reg <= 1'b0;
        end else begin
            ext_reg <= ext_next;
        end
    end

    assign EXT_HF_CLOCK_SELECT = ext_reg;

    // ***************************************************
    // oscillator pin synchroniser and edge count
    // ***************************************************
    logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
    logic stop_s1_reg, stop_s2_reg, stop_s3_reg;
    logic lpm_s1_reg, lpm_s2_reg;
    logic [CSP_WARMUP_W-1:0] warm_reg, warm_next;
    logic osc_en_reg, osc_en_next;
    logic hf_edge, warm_done;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            stop_s1_reg <= 1'b0;
            stop_s2_reg <= 1'b0;
            stop_s3_reg <= 1'b0;
            lpm_s1_reg <= 1'b0;
            lpm_s2_reg <= 1'b0;
        end else begin
            osc_s1_reg <= OSC_IN_PIN;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            stop_s1_reg <= STOP_MODE;
            stop_s2_reg <= stop_s1_reg;
            stop_s3_reg <= stop_s2_reg;
            lpm_s1_reg <= LOW_POWER_MODE;
            lpm_s2_reg <= lpm_s1_reg;
        end
    end

    assign hf_edge = osc_s2_reg && !osc_s3_reg;
    assign warm_done = (warm_reg == WARMUP_CYCLES);

    always_comb begin
        warm_next = warm_reg;
        // crystal is off in stop, so the count restarts on the way out
        osc_en_next = !ext_reg && !stop_s2_reg;
        if (stop_s2_reg || (stop_s3_reg && !stop_s2_reg)) begin
            warm_next = '0;
        end else if (hf_edge && !warm_done) begin
            warm_next = warm_reg + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            warm_reg <= '0;
            osc_en_reg <= 1'b0;
        end else begin
            warm_reg <= warm_next;
            osc_en_reg <= osc_en_next;
        end
    end

    assign OSC_ENABLE = osc_en_reg;

    // ***************************************************
    // source switch, break before make
    // ***************************************************
    csp_src_e src_reg, src_next;
    logic [CSP_GAP_W-1:0] gap_reg, gap_next;
    logic want_hf;

    assign want_hf = warm_done && !lpm_s2_reg && !stop_s2_reg;

    always_comb begin
        src_next = src_reg;
        gap_next = gap_reg;
        unique case (src_reg)
            CSP_SRC_RC: begin
                if (want_hf) begin
                    src_next = CSP_SRC_TO_HF;
                    gap_next = CSP_SWITCH_GAP;
                end
            end
            CSP_SRC_TO_HF: begin
                gap_next = gap_reg - 1'b1;
                if (!want_hf) begin
                    src_next = CSP_SRC_RC;
                end else if (gap_reg == '0) begin
                    src_next = CSP_SRC_HF;
                end
            end
            CSP_SRC_HF: begin
                if (!want_hf) begin
                    src_next = CSP_SRC_TO_RC;
                    gap_next = CSP_SWITCH_GAP;
                end
            end
            CSP_SRC_TO_RC: begin
                gap_next = gap_reg - 1'b1;
                if (gap_reg == '0) begin
                    src_next = CSP_SRC_RC;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            src_reg <= CSP_SRC_RC;
            gap_reg <= '0;
        end else begin
            src_reg <= src_next;
            gap_reg <= gap_next;
        end
    end

    // gaps idle both gates so no shortened pulse can pass
    assign CLK_STATUS.rc_gate_en = (src_reg == CSP_SRC_RC);
    assign CLK_STATUS.hf_gate_en = (src_reg == CSP_SRC_HF);
    assign CLK_STATUS.warmup_done = warm_done;

    // ***************************************************
    // serial configuration, loaded only on update
    // ***************************************************
    csp_cfg_s cfg_reg, cfg_next;

    always_comb begin
        cfg_next = cfg_reg;
        if (MIRROR_TO_HW_UPDATE) begin
            cfg_next = SERIAL_PORT_CONFIG_MIRROR;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_reg <= CSP_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign SERIAL_PORT_CONFIG = cfg_reg;

    // ***************************************************
    // link domain: shift register on the sample clock
    // ***************************************************
    // polarity xor phase maps every mode onto a rising sample edge;
    // config changes only between frames, so the xor cannot glitch mid byte
    logic sample_clk, ssel_act, link_rst_n;
    logic [2:0] bit_reg, bit_next;
    logic [CSP_BYTE_W-2:0] sh_reg, sh_next;
    logic [CSP_BYTE_W-1:0] rxb_reg, rxb_next;
    logic rxt_reg, rxt_next;
    logic [CSP_BYTE_W-1:0] txs_reg, txs_next;
    logic [CSP_BYTE_W-1:0] tx_hold_reg, tx_hold_next;

    assign sample_clk = SCLK ^ (cfg_reg.clock_idle_polarity ^ cfg_reg.clock_sample_phase);
    assign ssel_act = SSEL ^ !cfg_reg.select_active_high;
    // deselect ends the frame and clears the bit position
    assign link_rst_n = RST_N && ssel_act;

    always_comb begin
        bit_next = bit_reg + 1'b1;
        sh_next = {sh_reg[CSP_BYTE_W-3:0], MOSI};
        rxb_next = rxb_reg;
        rxt_next = rxt_reg;
        if (bit_reg == CSP_BIT_LAST) begin
            rxb_next = {sh_reg, MOSI};
            rxt_next = !rxt_reg;
        end
    end

    always_ff @(posedge sample_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_reg <= CSP_BIT_FIRST;
            sh_reg <= '0;
        end else begin
            bit_reg <= bit_next;
            sh_reg <= sh_next;
        end
    end

    always_ff @(posedge sample_clk or negedge RST_N) begin
        if (!RST_N) begin
            rxb_reg <= '0;
            rxt_reg <= 1'b0;
        end else begin
            rxb_reg <= rxb_next;
            rxt_reg <= rxt_next;
        end
    end

    // hold is copied at the shift edge after the first sample, which every mode has
    always_comb begin
        txs_next = {txs_reg[CSP_BYTE_W-2:0], 1'b0};
        if (bit_reg == CSP_BIT_FIRST + 3'h1) begin
            txs_next = {tx_hold_reg[CSP_BYTE_W-2:0], 1'b0};
        end
    end

    always_ff @(negedge sample_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            txs_reg <= CSP_TX_IDLE;
        end else begin
            txs_reg <= txs_next;
        end
    end

    // phase 0 presents the top bit before the first edge
    assign MISO_O = (bit_reg == CSP_BIT_FIRST) ? tx_hold_reg[CSP_BYTE_W-1]
                                                : txs_reg[CSP_BYTE_W-1];
    assign MISO_OE = ssel_act;

    // ***************************************************
    // byte crossing into the system clock and receive fifo
    // ***************************************************
    logic rxt_s1_reg, rxt_s2_reg, rxt_s3_reg;
    logic pend_reg, pend_next;
    logic ovr_reg, ovr_next;
    logic [CSP_BYTE_W-1:0] pend_data_reg, pend_data_next;
    logic rx_event, fifo_in_ready;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rxt_s1_reg <= 1'b0;
            rxt_s2_reg <= 1'b0;
            rxt_s3_reg <= 1'b0;
        end else begin
            rxt_s1_reg <= rxt_reg;
            rxt_s2_reg <= rxt_s1_reg;
            rxt_s3_reg <= rxt_s2_reg;
        end
    end

    // rxb is stable for the inter-byte gap, long past the toggle sync
    assign rx_event = rxt_s2_reg ^ rxt_s3_reg;

    always_comb begin
        pend_next = pend_reg;
        pend_data_next = pend_data_reg;
        ovr_next = ovr_reg;
        if (pend_reg && fifo_in_ready) begin
            pend_next = 1'b0;
        end
        if (rx_event) begin
            // a full fifo with a byte still waiting loses that waiting byte
            if (pend_reg && !fifo_in_ready) begin
                ovr_next = 1'b1;
            end
            pend_next = 1'b1;
            pend_data_next = rxb_reg;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_reg <= 1'b0;
            pend_data_reg <= '0;
            ovr_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            pend_data_reg <= pend_data_next;
            ovr_reg <= ovr_next;
        end
    end

    assign RX_OVERRUN = ovr_reg;

    csp_fifo #(
        .WIDTH(CSP_BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(pend_reg),
        .in_ready(fifo_in_ready),
        .in_data(pend_data_reg),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .out_data(RX_DATA)
    );

    // ***************************************************
    // reply byte holding register
    // ***************************************************
    logic tx_full_reg, tx_full_next;

    always_comb begin
        tx_hold_next = tx_hold_reg;
        tx_full_next = tx_full_reg;
        if (rx_event) begin
            tx_full_next = 1'b0;
        end
        if (TX_VALID && !tx_full_reg) begin
            tx_hold_next = TX_DATA;
            tx_full_next = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_hold_reg <= CSP_TX_IDLE;
            tx_full_reg <= 1'b0;
        end else begin
            tx_hold_reg <= tx_hold_next;
            tx_full_reg <= tx_full_next;
        end
    end

    assign TX_READY = !tx_full_reg;

    // ***************************************************
    // interrupt request line
    // ***************************************************
    logic irq_n_reg, irq_n_next;

    always_comb begin
        irq_n_next = !IRQ_REQ;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= irq_n_next;
        end
    end

    assign IRQ_N = irq_n_reg;

endmodule

// file: csp_pkg.sv
// csp_pkg: shared constants and types for the clock select and serial slave block
// assumes: included before csp_fifo and csp_clk_spi_top
package csp_pkg;

    // ***************************************************
    // widths and timing
    // ***************************************************
    localparam int CSP_BYTE_W = 8;
    localparam int CSP_FIFO_DEPTH = 4;
    localparam int CSP_WARMUP_W = 17;
    localparam logic [CSP_WARMUP_W-1:0] CSP_WARMUP_CYCLES = 17'h1_0000;
    localparam int CSP_GAP_W = 4;
    localparam logic [CSP_GAP_W-1:0] CSP_SWITCH_GAP = 4'h4;
    localparam logic [2:0] CSP_BIT_LAST = 3'h7;
    localparam logic [2:0] CSP_BIT_FIRST = 3'h0;
    localparam logic [CSP_BYTE_W-1:0] CSP_TX_IDLE = 8'h00;

    // ***************************************************
    // serial port configuration field positions
    // ***************************************************
    localparam int CSP_CFG_POL = 0;
    localparam int CSP_CFG_PHA = 1;
    localparam int CSP_CFG_SEL = 2;
    localparam logic [2:0] CSP_CFG_RESET = 3'h0;

    typedef struct packed {
        logic select_active_high;
        logic clock_sample_phase;
        logic clock_idle_polarity;
    } csp_cfg_s;

    typedef struct packed {
        logic hf_gate_en;
        logic rc_gate_en;
        logic warmup_done;
    } csp_clk_stat_s;

    typedef enum logic [1:0] {
        CSP_SRC_RC,
        CSP_SRC_TO_HF,
        CSP_SRC_HF,
        CSP_SRC_TO_RC
    } csp_src_e;

endpackage

// file: csp_fifo.sv
// csp_fifo: small synchronous fifo, flip-flop storage, valid/ready on both sides
// assumes: one clock; write and read may occur in the same cycle
`timescale 1ns/1ps
module csp_fifo
    import csp_pkg::*;
#(
    parameter int WIDTH = CSP_BYTE_W,
    parameter int DEPTH = CSP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != FULL_COUNT);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == LAST_IDX) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == LAST_IDX) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage holds no control state, so it needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

endmodule

// file: csp_clk_spi_props.sv
// csp_clk_spi_props: port-level checker for the clock select and serial slave block
// assumes: bound to every csp_clk_spi_top instance; all checks on the system clock
`timescale 1ns/1ps
module csp_clk_spi_props
    import csp_pkg::*;
#(
    parameter logic [CSP_WARMUP_W-1:0] WARMUP_CYCLES = CSP_WARMUP_CYCLES,
    parameter int FIFO_DEPTH = CSP_FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic POR_RST_N,
    input wire logic LOW_POWER_MODE,
    input wire logic STOP_MODE,
    input wire logic EXT_HF_CLOCK_SELECT_WR,
    input wire logic EXT_HF_CLOCK_SELECT_VAL,
    input wire logic EXT_HF_CLOCK_SELECT,
    input wire logic OSC_ENABLE,
    input wire csp_clk_stat_s CLK_STATUS,
    input wire csp_cfg_s SERIAL_PORT_CONFIG_MIRROR,
    input wire logic MIRROR_TO_HW_UPDATE,
    input wire csp_cfg_s SERIAL_PORT_CONFIG,
    input wire logic SSEL,
    input wire logic MISO_OE,
    input wire logic IRQ_REQ,
    input wire logic IRQ_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // ***************************************************
    // clock source
    // ***************************************************
    sequence rc_released;
        $fell(CLK_STATUS.rc_gate_en);
    endsequence
    // dead gap keeps a runt pulse away from the logic
    sequence hf_after_gap;
        (!CLK_STATUS.hf_gate_en)[*5] ##1 CLK_STATUS.hf_gate_en;
    endsequence
    sequence lp_held;
        LOW_POWER_MODE[*8] ##1 LOW_POWER_MODE[*8];
    endsequence

    gates_apart_a: assert property (!(CLK_STATUS.hf_gate_en && CLK_STATUS.rc_gate_en))
        else $error("both clock gates enabled");
    switch_gap_a: assert property (rc_released |-> hf_after_gap)
        else $error("hf gate not enabled after the switch gap");
    hf_needs_warm_a: assert property ($rose(CLK_STATUS.hf_gate_en) |-> CLK_STATUS.warmup_done)
        else $error("hf gate enabled before warmup done");
    low_power_rc_a: assert property (lp_held |-> CLK_STATUS.rc_gate_en && !CLK_STATUS.hf_gate_en)
        else $error("low power mode not on the rc clock");
    stop_cold_a: assert property (STOP_MODE[*6] |-> !CLK_STATUS.warmup_done && !OSC_ENABLE)
        else $error("stop mode kept warmup or oscillator");
    ext_write_a: assert property (disable iff (!POR_RST_N)
        EXT_HF_CLOCK_SELECT_WR |=> EXT_HF_CLOCK_SELECT == $past(EXT_HF_CLOCK_SELECT_VAL))
        else $error("ext clock bit not written");
    ext_keep_a: assert property (disable iff (!POR_RST_N)
        !EXT_HF_CLOCK_SELECT_WR |=> $stable(EXT_HF_CLOCK_SELECT))
        else $error("ext clock bit changed without a write");
    osc_off_a: assert property (EXT_HF_CLOCK_SELECT |=> !OSC_ENABLE)
        else $error("oscillator on with ext clock selected");

    // ***************************************************
    // serial format and request line
    // ***************************************************
    cfg_reset_a: assert property ($rose(RST_N) |-> SERIAL_PORT_CONFIG == CSP_CFG_RESET)
        else $error("serial format not default after reset");
    cfg_load_a: assert property (MIRROR_TO_HW_UPDATE |=>
        SERIAL_PORT_CONFIG == $past(SERIAL_PORT_CONFIG_MIRROR))
        else $error("mirror not copied on update");
    cfg_hold_a: assert property (!MIRROR_TO_HW_UPDATE |=> $stable(SERIAL_PORT_CONFIG))
        else $error("serial format changed without update");
    sel_drive_a: assert property (MISO_OE == (SSEL == SERIAL_PORT_CONFIG.select_active_high))
        else $error("output enable does not follow select");
    irq_follow_a: assert property (1'b1 |=> IRQ_N == !$past(IRQ_REQ))
        else $error("request line does not follow source");
endmodule

bind csp_clk_spi_top csp_clk_spi_props #(.WARMUP_CYCLES(WARMUP_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
    u_props (.CLK(CLK), .RST_N(RST_N), .POR_RST_N(POR_RST_N), .LOW_POWER_MODE(LOW_POWER_MODE),
    .STOP_MODE(STOP_MODE), .EXT_HF_CLOCK_SELECT_WR(EXT_HF_CLOCK_SELECT_WR),
    .EXT_HF_CLOCK_SELECT_VAL(EXT_HF_CLOCK_SELECT_VAL), .EXT_HF_CLOCK_SELECT(EXT_HF_CLOCK_SELECT),
    .OSC_ENABLE(OSC_ENABLE), .CLK_STATUS(CLK_STATUS),
    .SERIAL_PORT_CONFIG_MIRROR(SERIAL_PORT_CONFIG_MIRROR),
    .MIRROR_TO_HW_UPDATE(MIRROR_TO_HW_UPDATE), .SERIAL_PORT_CONFIG(SERIAL_PORT_CONFIG),
    .SSEL(SSEL), .MISO_OE(MISO_OE), .IRQ_REQ(IRQ_REQ), .IRQ_N(IRQ_N));

// file: csp_spi_master.sv
// csp_spi_master: behavioural shift-clock master facing the serial slave
// assumes: driven by task calls from the bench; the bench resolves the reply wire
`timescale 1ns/1ps
module csp_spi_master #(
    parameter realtime HALF = 15.0
) (
    output logic sclk,
    output logic mosi,
    output logic ssel,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ssel = 1'b1;
    end

    // clock parks at idle; released data line flips so a stale bit never looks valid
    task automatic idle(input logic pol, input logic sh);
        sclk = pol;
        ssel = !sh;
        mosi = !mosi;
    endtask

    // 30 ns shift clock stays under a quarter of the system clock
    task automatic xfer(input logic pol, input logic pha, input logic sh,
            input logic [7:0] tx, input logic keep, output logic [7:0] rx);
        ssel = sh;
        sclk = pol;
        for (int i = 7; i >= 0; i--) begin
            if (!pha) mosi = tx[i];
            #HALF;
            sclk = !pol;
            if (pha) mosi = tx[i]; else rx[i] = miso;
            #HALF;
            sclk = pol;
            if (pha) rx[i] = miso;
        end
        #HALF;
        if (!keep) idle(pol, sh);
    endtask
endmodule

// file: csp_clk_spi_top_test.sv
// csp_clk_spi_top_test: self-checking bench for the clock select and serial slave block
// assumes: csp_pkg, csp_fifo, csp_clk_spi_top, the checker and the master model compiled first
`timescale 1ns/1ps
module csp_clk_spi_top_test
    import csp_pkg::*;
;
    localparam logic [CSP_WARMUP_W-1:0] WARM = 17'h0_0010;
    logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, osc = 1'b0, osc_run = 1'b0;
    logic lp = 1'b0, stop = 1'b0, ext_wr = 1'b0, ext_val = 1'b0, upd = 1'b0, irq_req = 1'b0;
    logic rx_ready = 1'b0, tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    csp_cfg_s mirror = '0;
    csp_cfg_s cfg;
    csp_clk_stat_s stat;
    logic ext_q, osc_en, sclk, mosi, ssel, miso_o, miso_oe, rx_valid, overrun, tx_ready, irq_n;
    logic miso_w;
    logic [7:0] rx_data, d, t, got;
    logic [7:0] q [6];
    int n_fail = 0, cmp_count = 0, seed = 32'ha296445f, edges = 0, r;

    always #2 clk = !clk;
    // osc pin held at ground until osc_run releases it
    always #12 osc = osc_run ? !osc : 1'b0;
    always @(posedge osc) edges++;
    // reply line has a pull-up when the slave lets go
    assign miso_w = miso_oe ? miso_o : 1'b1;

    csp_clk_spi_top #(.WARMUP_CYCLES(WARM), .FIFO_DEPTH(CSP_FIFO_DEPTH)) u_dut (
        .CLK(clk), .RST_N(rst_n), .POR_RST_N(por_n), .OSC_IN_PIN(osc),
        .LOW_POWER_MODE(lp), .STOP_MODE(stop), .EXT_HF_CLOCK_SELECT_WR(ext_wr),
        .EXT_HF_CLOCK_SELECT_VAL(ext_val), .EXT_HF_CLOCK_SELECT(ext_q), .OSC_ENABLE(osc_en),
        .CLK_STATUS(stat), .SERIAL_PORT_CONFIG_MIRROR(mirror), .MIRROR_TO_HW_UPDATE(upd),
        .SERIAL_PORT_CONFIG(cfg), .SCLK(sclk), .MOSI(mosi), .SSEL(ssel), .MISO_O(miso_o),
        .MISO_OE(miso_oe), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .RX_OVERRUN(overrun), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .IRQ_REQ(irq_req), .IRQ_N(irq_n)
    );
    csp_spi_master u_master (.sclk(sclk), .mosi(mosi), .ssel(ssel), .miso(miso_w));

    // ***************************************************
    // helpers
    // ***************************************************
    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v, input string what);
        cmp_count++;
        if (got_v !== exp_v) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        n_fail++;
        $display("Error at %0t: %s timed out", $time, what);
        end_of_test();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_hf(input int lim);
        int k;
        for (k = 0; k < lim && stat.hf_gate_en !== 1'b1; k++) @(posedge clk);
        if (k == lim) give_up("clock switch");
    endtask

    task automatic load_tx(input logic [7:0] v);
        int k;
        @(posedge clk);
        tx_data <= v;
        tx_valid <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge clk);
            if (tx_ready === 1'b1) break;
        end
        if (k == 200) give_up("reply load");
        tx_valid <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] v);
        int k;
        for (k = 0; k < 200; k++) begin
            @(posedge clk);
            if (rx_valid === 1'b1) break;
        end
        if (k == 200) give_up("receive");
        chk(rx_data, v, "received byte");
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask

    // ***************************************************
    // sequence
    // ***************************************************
    initial begin
        cyc(6);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        cyc(2);
        chk(cfg, CSP_CFG_RESET, "format after reset");
        chk(stat, 8'h02, "clock status after reset");
        cyc(200);
        chk(stat, 8'h02, "no oscillator edges");
        $display("done: reset and dead oscillator");
        osc_run <= 1'b1;
        wait_hf(4000);
        chk(edges >= WARM, 8'h01, "warmup length");
        lp <= 1'b1;
        cyc(30);
        chk({stat.hf_gate_en, stat.rc_gate_en}, 8'h01, "low power source");
        lp <= 1'b0;
        wait_hf(100);
        stop <= 1'b1;
        cyc(20);
        chk({stat.warmup_done, osc_en}, 8'h00, "stop mode");
        stop <= 1'b0;
        edges = 0;
        wait_hf(4000);
        chk(edges >= WARM, 8'h01, "warmup after stop");
        $display("done: clock source");
        ext_val <= 1'b1;
        ext_wr <= 1'b1;
        cyc(1);
        ext_wr <= 1'b0;
        cyc(2);
        chk({ext_q, osc_en}, 8'h02, "ext clock select");
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        chk({ext_q, stat.hf_gate_en}, 8'h02, "ext bit kept over reset");
        por_n <= 1'b0;
        cyc(2);
        por_n <= 1'b1;
        cyc(2);
        chk(ext_q, 8'h00, "ext bit cleared by power-on");
        wait_hf(4000);
        repeat (20) begin
            r = $random(seed);
            irq_req <= r[0];
            cyc(2);
            chk(irq_n, !r[0], "request line");
        end
        $display("done: ext clock and request line");
        for (int m = 0; m < 8; m++) begin
            mirror <= m[2:0];
            cyc(2);
            chk(cfg, (m == 0) ? 8'h00 : 8'(m - 1), "format before update");
            u_master.idle(m[0], m[2]);
            upd <= 1'b1;
            cyc(1);
            upd <= 1'b0;
            cyc(1);
            chk(cfg, 8'(m), "format after update");
            repeat (2) begin
                d = 8'($random(seed));
                t = 8'($random(seed));
                load_tx(t);
                u_master.xfer(m[0], m[1], m[2], d, m[1], got);
                chk(got, t, "reply byte");
                rd(d);
                cyc(400);
            end
            u_master.idle(m[0], m[2]);
            $display("done: format %0d", m);
        end
        for (int i = 0; i < 6; i++) begin
            q[i] = 8'($random(seed));
            u_master.xfer(1'b1, 1'b1, 1'b1, q[i], 1'b0, got);
            cyc(400);
        end
        chk(overrun, 8'h01, "overrun flag");
        for (int i = 0; i < 4; i++) rd(q[i]);
        rd(q[5]);
        cyc(10);
        chk(rx_valid, 8'h00, "receive drained");
        $display("done: buffer fill and drain");
        end_of_test();
    end

    initial begin
        #300_000;
        give_up("run");
    end
endmodule
